// ==== hdl/pscl_pkg.sv ====
// Shared constants and types for the passive serial configuration loader
package pscl_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CNT_W         = 16;
  localparam int WORD_W        = 8;
  localparam int CFG_WORDS     = 8;

  // Least time rounds up, longest time rounds down, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int T_CF2ST0_NS      = 600;
  localparam int CF2ST0_CYC       = cyc_dn(T_CF2ST0_NS);
  localparam int T_CFG_US         = 2;
  localparam int CFG_CYC          = cyc_up(T_CFG_US * 1000);
  localparam int T_STATUS_MIN_US  = 268;
  localparam int STATUS_MIN_CYC   = cyc_up(T_STATUS_MIN_US * 1000);
  localparam int T_STATUS_MAX_US  = 1506;
  localparam int STATUS_MAX_CYC   = cyc_dn(T_STATUS_MAX_US * 1000);
  localparam int T_CF2CK_US       = 1506;
  localparam int CF2CK_CYC        = cyc_up(T_CF2CK_US * 1000);
  localparam int T_ST2CK_US       = 2;
  localparam int ST2CK_CYC        = cyc_up(T_ST2CK_US * 1000);
  localparam int T_CD2UM_MIN_US   = 175;
  localparam int CD2UM_MIN_CYC    = cyc_up(T_CD2UM_MIN_US * 1000);
  localparam int T_CD2UM_MAX_US   = 437;
  localparam int CD2UM_MAX_CYC    = cyc_dn(T_CD2UM_MAX_US * 1000);
  localparam int T_CCLK_MIN_NS    = 8;
  localparam int CD2CU_PERIODS    = 4;
  localparam int CD2CU_CYC        = cyc_up(CD2CU_PERIODS * T_CCLK_MIN_NS);
  localparam int USR_INIT_PERIODS = 17408;
  localparam int DONE_EDGES       = 2;

  localparam int F_OSC_MAX_KHZ    = 12500;
  localparam int F_PS_USR_MAX_KHZ = 125000;
  localparam int F_AS_USR_MAX_KHZ = 100000;
  localparam int F_SYS_KHZ        = 20000;

  localparam int OPT_INIT_BIT     = 0;
  localparam int OPT_USRCLK_BIT   = 1;
  localparam int OPT_DOUT_BIT     = 2;
  localparam int OPT_W            = 3;

  typedef enum logic [2:0] {
    DS_POR     = 3'h0,
    DS_RESET   = 3'h1,
    DS_STATUS  = 3'h2,
    DS_LOAD    = 3'h3,
    DS_DONE    = 3'h4,
    DS_USRINIT = 3'h5,
    DS_USER    = 3'h6,
    DS_ERROR   = 3'h7
  } pscl_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'h0,
    HS_REQ   = 3'h1,
    HS_WAIT  = 3'h2,
    HS_SHIFT = 3'h3,
    HS_EDGES = 3'h4,
    HS_RUN   = 3'h5,
    HS_ERR   = 3'h6
  } pscl_host_state_t;
endpackage

// ==== hdl/pscl_if.sv ====
// Configuration link between the host and the loading device
`timescale 1ns/100ps
interface pscl_if;
  logic config_request_n;
  logic config_clock;
  logic user_startup_clock;
  logic host_data;
  logic dev_data_out;
  logic dev_data_oe_n;
  logic dev_status_oe_n;
  logic host_status_oe_n;
  logic load_complete;
  logic init_oe_n;
  logic status_n;
  logic serial_data_in;
  logic init_complete;

  // Open-drain lines: low when any end enables its driver, else pulled high
  assign status_n       = dev_status_oe_n & host_status_oe_n;
  assign init_complete  = init_oe_n;
  assign serial_data_in = dev_data_oe_n ? host_data : dev_data_out;

  modport device (
    input  config_request_n, config_clock, user_startup_clock, status_n, serial_data_in,
    output dev_data_out, dev_data_oe_n, dev_status_oe_n, load_complete, init_oe_n
  );
  modport host (
    input  status_n, load_complete, init_complete,
    output config_request_n, config_clock, user_startup_clock, host_data, host_status_oe_n
  );
endinterface

// ==== hdl/pscl_device.sv ====
// Device end: passive serial configuration loader with init sequencing
// Summary of operation
// - Request low abandons user mode, restarts loading
// - Status held low through power-on delay
// - Load complete low until bitstream accepted
// - Config clock ignored once the two closing edges are counted
// - Data pin becomes user I/O per option
// - Load complete rises only on error-free bitstream
// - Host gives two falling edges after completion
// - Init complete driven low once option loaded
// - Request low pulls both lines low quickly
// - Host holds request low at least 2 us
// - Status low at least 268 us
// - Status released within 1506 us of request
// - Host waits before first config clock edge
// - Data captured on config clock rising edge
// - Oscillator init lasts 175 to 437 us
// - Startup clock enabled after four clock periods
// - Startup clock init needs 17408 periods
// - Init clock frequency limits per scheme
// - Startup clock used only when option set
`timescale 1ns/100ps
module pscl_device
  import pscl_pkg::*;
#(
  parameter int POR_CYC      = STATUS_MIN_CYC,
  parameter int STATUS_CYC   = STATUS_MIN_CYC,
  parameter int INIT_OSC_CYC = CD2UM_MIN_CYC,
  parameter int USR_INIT_CYC = USR_INIT_PERIODS,
  parameter int NUM_WORDS    = CFG_WORDS
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  pscl_if.device                 link,
  output logic [WORD_W-1:0]      cfg_word,
  output logic                   cfg_valid,
  input  wire logic              cfg_ready,
  output logic                   user_mode,
  output logic                   init_clk_user,
  output logic                   config_error,
  input  wire logic              user_data_out,
  output logic                   user_data_in
);

  typedef struct packed {
    pscl_dev_state_t              st;
    logic [CNT_W-1:0]             cnt;
    logic                         req_s1;
    logic                         req_s2;
    logic                         cc_s1;
    logic                         cc_s2;
    logic                         cc_s3;
    logic                         dat_s1;
    logic                         dat_s2;
    logic                         sts_s1;
    logic                         sts_s2;
    logic                         uc_s1;
    logic                         uc_s2;
    logic                         uc_s3;
    logic [WORD_W-1:0]            sr;
    logic [2:0]                   bitcnt;
    logic [7:0]                   wordcnt;
    logic [WORD_W-1:0]            sum;
    logic [OPT_W-1:0]             opts;
    logic [1:0]                   edges;
    logic [1:0][WORD_W-1:0]       fifo;
    logic                         wp;
    logic                         rp;
    logic [1:0]                   fcnt;
    logic                         stat_lo;
    logic                         done;
    logic                         init_lo;
    logic                         dout;
    logic                         err;
  } pscl_dev_s_t;

  localparam pscl_dev_s_t DEV_RST = '{st: DS_POR, stat_lo: 1'b1, default: '0};

  pscl_dev_s_t s_reg;
  pscl_dev_s_t s_next;

  logic              cc_rise;
  logic              cc_fall;
  logic              uc_rise;
  logic              push;
  logic              pop;
  logic [WORD_W-1:0] word;

  always_comb begin
    s_next = s_reg;
    // Two-stage synchronisers on every pin from the host
    s_next.req_s1 = link.config_request_n;
    s_next.req_s2 = s_reg.req_s1;
    s_next.cc_s1  = link.config_clock;
    s_next.cc_s2  = s_reg.cc_s1;
    s_next.cc_s3  = s_reg.cc_s2;
    s_next.dat_s1 = link.serial_data_in;
    s_next.dat_s2 = s_reg.dat_s1;
    s_next.sts_s1 = link.status_n;
    s_next.sts_s2 = s_reg.sts_s1;
    s_next.uc_s1  = link.user_startup_clock;
    s_next.uc_s2  = s_reg.uc_s1;
    s_next.uc_s3  = s_reg.uc_s2;
    s_next.dout   = user_data_out;

    cc_rise = s_reg.cc_s2 & ~s_reg.cc_s3;
    cc_fall = ~s_reg.cc_s2 & s_reg.cc_s3;
    uc_rise = s_reg.uc_s2 & ~s_reg.uc_s3;
    word    = {s_reg.sr[WORD_W-2:0], s_reg.dat_s2};
    push    = 1'b0;
    pop     = cfg_ready && (s_reg.fcnt != 2'h0);

    case (s_reg.st)
      DS_POR: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt >= CNT_W'(POR_CYC - 1)) begin
          s_next.st  = DS_LOAD;
          s_next.cnt = '0;
        end
      end
      DS_RESET: begin
        s_next.cnt = '0;
        if (s_reg.req_s2) begin
          s_next.st = DS_STATUS;
        end
      end
      DS_STATUS: begin
        // Fixed minimum hold keeps well inside the release bound
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt >= CNT_W'(STATUS_CYC - 1)) begin
          s_next.st  = DS_LOAD;
          s_next.cnt = '0;
        end
      end
      DS_LOAD: begin
        // Edges ignored while another party stretches status low
        if (cc_rise && s_reg.sts_s2) begin
          s_next.sr     = word;
          s_next.bitcnt = s_reg.bitcnt + 1'b1;
          if (s_reg.bitcnt == 3'h7) begin
            s_next.wordcnt = s_reg.wordcnt + 1'b1;
            s_next.sum     = s_reg.sum ^ word;
            if (s_reg.wordcnt == 8'h00) begin
              s_next.opts = word[OPT_W-1:0];
            end
            if (s_reg.wordcnt == 8'(NUM_WORDS - 1)) begin
              // Last word is the XOR of all earlier ones
              if (s_reg.sum == word) begin
                s_next.st    = DS_DONE;
                s_next.cnt   = '0;
                s_next.edges = '0;
              end else begin
                s_next.st = DS_ERROR;
              end
            end else if (s_reg.fcnt == 2'h2 && !pop) begin
              // Serial link cannot stall, so overflow is an error
              s_next.st = DS_ERROR;
            end else begin
              push = 1'b1;
            end
          end
        end
      end
      DS_DONE: begin
        if (s_reg.cnt != '1) begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
        if (cc_fall && s_reg.edges != 2'(DONE_EDGES)) begin
          s_next.edges = s_reg.edges + 1'b1;
        end
        if (s_reg.edges == 2'(DONE_EDGES)) begin
          if (s_reg.opts[OPT_USRCLK_BIT]) begin
            if (s_reg.cnt >= CNT_W'(CD2CU_CYC)) begin
              s_next.st  = DS_USRINIT;
              s_next.cnt = '0;
            end
          end else if (s_reg.cnt >= CNT_W'(INIT_OSC_CYC - 1)) begin
            s_next.st = DS_USER;
          end
        end
      end
      DS_USRINIT: begin
        if (uc_rise) begin
          s_next.cnt = s_reg.cnt + 1'b1;
          if (s_reg.cnt == CNT_W'(USR_INIT_CYC - 1)) begin
            s_next.st = DS_USER;
          end
        end
      end
      DS_USER: begin
        s_next.cnt = '0;
      end
      DS_ERROR: begin
        s_next.cnt = '0;
      end
      default: begin
        s_next.st = DS_POR;
      end
    endcase

    // Request low wins from any state after power-on
    if (!s_reg.req_s2 && s_reg.st != DS_POR) begin
      s_next.st      = DS_RESET;
      s_next.opts    = '0;
      s_next.sr      = '0;
      s_next.bitcnt  = '0;
      s_next.wordcnt = '0;
      s_next.sum     = '0;
      s_next.fcnt    = '0;
      s_next.wp      = 1'b0;
      s_next.rp      = 1'b0;
      push           = 1'b0;
      pop            = 1'b0;
    end

    if (push) begin
      s_next.fifo[s_reg.wp] = word;
      s_next.wp             = ~s_reg.wp;
    end
    if (pop) begin
      s_next.rp = ~s_reg.rp;
    end
    s_next.fcnt = s_next.fcnt + {1'b0, push} - {1'b0, pop};

    s_next.stat_lo = (s_next.st == DS_POR) || (s_next.st == DS_RESET) ||
                     (s_next.st == DS_STATUS) || (s_next.st == DS_ERROR);
    s_next.done    = (s_next.st == DS_DONE) || (s_next.st == DS_USRINIT) ||
                     (s_next.st == DS_USER);
    s_next.init_lo = s_next.opts[OPT_INIT_BIT] && (s_next.st != DS_USER) &&
                     (s_next.st != DS_RESET);
    s_next.err     = (s_next.st == DS_ERROR);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= DEV_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.dev_status_oe_n = ~s_reg.stat_lo;
  assign link.load_complete   = s_reg.done;
  assign link.init_oe_n       = ~s_reg.init_lo;
  assign link.dev_data_out    = s_reg.dout;
  assign link.dev_data_oe_n   = ~((s_reg.st == DS_USER) && s_reg.opts[OPT_DOUT_BIT]);
  assign cfg_word             = s_reg.fifo[s_reg.rp];
  assign cfg_valid            = (s_reg.fcnt != 2'h0);
  assign user_mode            = (s_reg.st == DS_USER);
  assign init_clk_user        = s_reg.opts[OPT_USRCLK_BIT];
  assign config_error         = s_reg.err;
  assign user_data_in         = s_reg.dat_s2;

endmodule

// ==== hdl/pscl_host.sv ====
// Host end: drives a configuration cycle and clocks the bitstream out
`timescale 1ns/100ps
module pscl_host
  import pscl_pkg::*;
#(
  parameter int CLK_HALF       = 4,
  parameter int USR_HALF       = 4,
  parameter bit MONITOR_STATUS = 1'b1,
  parameter int CF2CK_WAIT     = CF2CK_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  pscl_if.host                   link,
  input  wire logic              start,
  input  wire logic [WORD_W-1:0] word,
  input  wire logic              word_valid,
  output logic                   word_ready,
  output logic                   busy,
  output logic                   loaded,
  output logic                   error
);

  typedef struct packed {
    pscl_host_state_t  st;
    logic [CNT_W-1:0]  cnt;
    logic [7:0]        ph;
    logic              cclk;
    logic [7:0]        uph;
    logic              uclk;
    logic [WORD_W-1:0] sr;
    logic [2:0]        bits;
    logic              have;
    logic              data;
    logic              req_n;
    logic [1:0]        edges;
    logic              sts_s1;
    logic              sts_s2;
    logic              dn_s1;
    logic              dn_s2;
    logic              err;
  } pscl_host_s_t;

  localparam pscl_host_s_t HOST_RST = '{st: HS_IDLE, req_n: 1'b1, default: '0};

  pscl_host_s_t s_reg;
  pscl_host_s_t s_next;
  logic         tick;

  always_comb begin
    s_next        = s_reg;
    s_next.sts_s1 = link.status_n;
    s_next.sts_s2 = s_reg.sts_s1;
    s_next.dn_s1  = link.load_complete;
    s_next.dn_s2  = s_reg.dn_s1;

    // Divided clocks stay far below every init clock limit
    s_next.uph = s_reg.uph + 1'b1;
    if (s_reg.uph == 8'(USR_HALF - 1)) begin
      s_next.uph  = '0;
      s_next.uclk = ~s_reg.uclk;
    end
    tick = (s_reg.ph == 8'(CLK_HALF - 1));
    s_next.ph = tick ? 8'h00 : s_reg.ph + 1'b1;

    case (s_reg.st)
      HS_IDLE, HS_RUN, HS_ERR: begin
        s_next.cclk = 1'b0;
        if (start) begin
          s_next.st    = HS_REQ;
          s_next.cnt   = '0;
          s_next.req_n = 1'b0;
          s_next.err   = 1'b0;
        end
      end
      HS_REQ: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt >= CNT_W'(CFG_CYC - 1)) begin
          s_next.req_n = 1'b1;
          s_next.st    = HS_WAIT;
          s_next.cnt   = '0;
        end
      end
      HS_WAIT: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (MONITOR_STATUS && !s_reg.sts_s2) begin
          s_next.cnt = '0;
        end
        if (s_reg.cnt >= CNT_W'((MONITOR_STATUS ? ST2CK_CYC : CF2CK_WAIT) - 1)) begin
          s_next.st   = HS_SHIFT;
          s_next.have = 1'b0;
        end
      end
      HS_SHIFT: begin
        if (!s_reg.have) begin
          s_next.ph = '0;
          if (word_valid) begin
            s_next.sr   = word;
            s_next.bits = '0;
            s_next.have = 1'b1;
            s_next.data = word[WORD_W-1];
          end else if (s_reg.dn_s2) begin
            s_next.st    = HS_EDGES;
            s_next.edges = '0;
          end
        end else if (tick) begin
          s_next.cclk = ~s_reg.cclk;
          if (s_reg.cclk) begin
            // Next bit presented on the falling edge
            s_next.sr   = {s_reg.sr[WORD_W-2:0], 1'b0};
            s_next.data = s_reg.sr[WORD_W-2];
            s_next.bits = s_reg.bits + 1'b1;
            if (s_reg.bits == 3'h7) begin
              s_next.have = 1'b0;
            end
          end
        end
        if (!s_reg.sts_s2) begin
          s_next.st   = HS_ERR;
          s_next.err  = 1'b1;
          s_next.cclk = 1'b0;
        end
      end
      HS_EDGES: begin
        if (tick) begin
          s_next.cclk = ~s_reg.cclk;
          if (s_reg.cclk) begin
            s_next.edges = s_reg.edges + 1'b1;
            if (s_reg.edges == 2'(DONE_EDGES - 1)) begin
              s_next.st = HS_RUN;
            end
          end
        end
      end
      default: begin
        s_next.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= HOST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.config_request_n   = s_reg.req_n;
  assign link.config_clock       = s_reg.cclk;
  assign link.user_startup_clock = s_reg.uclk;
  assign link.host_data          = s_reg.data;
  assign link.host_status_oe_n   = 1'b1;
  assign word_ready              = (s_reg.st == HS_SHIFT) && !s_reg.have;
  assign busy                    = (s_reg.st != HS_IDLE) && (s_reg.st != HS_RUN) &&
                                   (s_reg.st != HS_ERR);
  assign loaded                  = (s_reg.st == HS_RUN);
  assign error                   = s_reg.err;

endmodule

// ==== verif/pscl_link_checker.sv ====
// Concurrent checks on the configuration link between host and device
`timescale 1ns/100ps
module pscl_link_checker
  import pscl_pkg::*;
#(
  parameter int STATUS_CYC = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic config_request_n,
  input wire logic config_clock,
  input wire logic status_n,
  input wire logic load_complete,
  input wire logic init_complete
);
  localparam int REL_MAX = STATUS_CYC + 20;
  logic [CNT_W-1:0] st_low_reg;
  logic [CNT_W-1:0] st_high_reg;
  logic [CNT_W-1:0] req_low_reg;

  // Saturating, so a long idle never wraps below a limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_low_reg  <= '0;
      st_high_reg <= '0;
      req_low_reg <= '0;
    end else begin
      st_low_reg  <= status_n ? '0 : st_low_reg + CNT_W'(st_low_reg != '1);
      st_high_reg <= !status_n ? '0 : st_high_reg + CNT_W'(st_high_reg != '1);
      req_low_reg <= config_request_n ? '0 : req_low_reg + CNT_W'(req_low_reg != '1);
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  req_fall_a: assert property (
    $fell(config_request_n) |-> ##[1:12] (!load_complete && !status_n))
    else $error("request fall not answered in time");
  status_min_a: assert property (
    $rose(status_n) |-> st_low_reg >= CNT_W'(STATUS_CYC))
    else $error("status low pulse too short");
  status_rel_a: assert property (
    $rose(config_request_n) |-> ##[1:REL_MAX] status_n)
    else $error("status not released in time");
  done_low_a: assert property (
    !status_n && $past(status_n, 2) == 1'b0 |-> !load_complete)
    else $error("load complete high while status low");
  done_hold_a: assert property (
    $fell(load_complete) |-> !$past(config_request_n, 2))
    else $error("load complete dropped without request");
  init_fall_a: assert property (
    $fell(init_complete) |-> !load_complete && status_n)
    else $error("init complete driven low outside loading");
  two_edges_a: assert property (
    $rose(load_complete) |-> ##[0:30] $fell(config_clock) ##[1:30] $fell(config_clock))
    else $error("two closing clock edges missing");
  clk_start_a: assert property (
    $rose(config_clock) |-> st_high_reg >= CNT_W'(ST2CK_CYC))
    else $error("config clock rose too soon after status");
  req_width_a: assert property (
    $rose(config_request_n) |-> req_low_reg >= CNT_W'(CFG_CYC))
    else $error("request pulse too short");

  cover property ($rose(load_complete));
  cover property ($fell(init_complete));
  cover property ($fell(status_n) && config_request_n);
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench: host and device joined across the configuration link
`timescale 1ns/100ps
module tb_top
  import pscl_pkg::*;
  ;
  localparam int NW   = 5;
  localparam int OSC  = 30;
  localparam int USRN = 20;
  localparam int POR  = 60;
  localparam logic [7:0] OPTS [4] = '{8'h00, 8'h03, 8'h05, 8'h06};
  logic              clk, rst_n, start, word_valid, cfg_ready, user_data_out, hold;
  logic [WORD_W-1:0] word, cfg_word;
  logic [15:0]       rnd;
  logic              word_ready, busy, loaded, error, cfg_valid, user_mode;
  logic              init_clk_user, config_error, user_data_in, init_seen;
  logic [WORD_W-1:0] got[$];
  int                errors, compares, n;

  pscl_if lk();
  pscl_host #(.CF2CK_WAIT(60)) i_pscl_host (.clk(clk), .rst_n(rst_n), .link(lk),
    .start(start), .word(word), .word_valid(word_valid), .word_ready(word_ready),
    .busy(busy), .loaded(loaded), .error(error));
  pscl_device #(.POR_CYC(POR), .STATUS_CYC(50), .INIT_OSC_CYC(OSC), .USR_INIT_CYC(USRN),
    .NUM_WORDS(NW)) i_pscl_device (.clk(clk), .rst_n(rst_n), .link(lk), .cfg_word(cfg_word),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .user_mode(user_mode),
    .init_clk_user(init_clk_user), .config_error(config_error),
    .user_data_out(user_data_out), .user_data_in(user_data_in));
  pscl_link_checker #(.STATUS_CYC(50)) i_pscl_link_checker (.clk(clk), .rst_n(rst_n),
    .config_request_n(lk.config_request_n), .config_clock(lk.config_clock),
    .status_n(lk.status_n), .load_complete(lk.load_complete),
    .init_complete(lk.init_complete));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Random stalls on the drain side; hold forces the buffer to fill
  always @(posedge clk) begin
    rnd       <= lfsr(rnd);
    cfg_ready <= !hold && (rnd[0] || rnd[5]);
    if (lk.init_complete === 1'b0) init_seen <= 1'b1;
    if (cfg_valid === 1'b1 && cfg_ready === 1'b1) got.push_back(cfg_word);
  end

  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok) begin
      errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic give_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic bit cond(input int k);
    case (k)
      0: return lk.status_n === 1'b1;
      1: return lk.load_complete === 1'b1;
      2: return user_mode === 1'b1;
      default: return config_error === 1'b1 && error === 1'b1;
    endcase
  endfunction

  task automatic wait_for(input int k, input int lim, output int c);
    for (c = 0; c < lim && !cond(k); c++) @(negedge clk);
    if (c >= lim) begin
      chk(1'b0, "wait timed out");
      give_verdict();
    end
  endtask

  // A refused frame stops the host, so its error ends the wait early
  task automatic send_word(input logic [WORD_W-1:0] w);
    int i;
    @(posedge clk);
    word       <= w;
    word_valid <= 1'b1;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (word_ready === 1'b1 || error === 1'b1) break;
    end
    word_valid <= 1'b0;
    if (i >= 400) chk(1'b0, "word never taken");
  endtask

  task automatic run_frame(input logic [7:0] opt, input bit bad, input bit stall);
    logic [WORD_W-1:0] d[NW];
    d[0]    = opt;
    d[NW-1] = opt;
    for (int i = 1; i < NW-1; i++) begin
      @(posedge clk);
      d[i]    = rnd[7:0];
      d[NW-1] = d[NW-1] ^ d[i];
    end
    if (bad) d[NW-1] = d[NW-1] ^ 8'h01;
    @(posedge clk);
    start <= 1'b1;
    hold  <= stall;
    @(posedge clk);
    start <= 1'b0;
    repeat (20) @(negedge clk);
    chk(user_mode === 1'b0 && lk.load_complete === 1'b0 && lk.status_n === 1'b0
        && busy === 1'b1, "no restart");
    init_seen = 1'b0;
    got.delete();
    for (int i = 0; i < NW; i++) send_word(d[i]);
    if (bad || stall) begin
      wait_for(3, 2000, n);
      chk(lk.load_complete === 1'b0 && lk.status_n === 1'b0 && busy === 1'b0
          && loaded === 1'b0, "bad frame accepted");
      return;
    end
    wait_for(1, 2000, n);
    wait_for(2, 1000, n);
    if (opt[1]) chk(n >= 8 * USRN - 8, "startup clock init too short");
    else chk(n >= OSC - 1 && n <= OSC + 20, "oscillator init out of window");
    chk(init_clk_user === opt[1], "init clock source");
    chk(init_seen === opt[0] && lk.init_complete === 1'b1, "init complete pin");
    // Options byte is handed over too; only the check byte is kept back
    chk(got.size() == NW - 1, "word count");
    for (int i = 0; i < NW-1 && i < got.size(); i++) chk(got[i] === d[i], "word");
    chk(loaded === 1'b1 && busy === 1'b0 && error === 1'b0, "host not finished");
    chk(lk.dev_data_oe_n === ~opt[2], "data pin direction");
    @(posedge clk);
    user_data_out <= rnd[2];
    repeat (6) @(negedge clk);
    chk(user_data_in === lk.serial_data_in
        && (!opt[2] || lk.serial_data_in === user_data_out), "user pin");
  endtask

  initial begin
    rst_n         = 1'b0;
    start         = 1'b0;
    word          = 8'h00;
    word_valid    = 1'b0;
    user_data_out = 1'b0;
    hold          = 1'b0;
    cfg_ready     = 1'b0;
    init_seen     = 1'b0;
    rnd           = 16'h131F;
    errors        = 0;
    compares      = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(negedge clk);
    chk(lk.status_n === 1'b0 && lk.load_complete === 1'b0, "power-on hold");
    wait_for(0, 200, n);
    chk(n >= POR - 41 && n <= POR - 30, "power-on hold length");
    foreach (OPTS[i]) run_frame(OPTS[i], 1'b0, 1'b0);
    run_frame(8'h07, 1'b1, 1'b0);
    run_frame(8'h01, 1'b0, 1'b0);
    // Drain held off: the two-entry buffer overflows
    run_frame(8'h00, 1'b0, 1'b1);
    give_verdict();
  end
endmodule
